/* File: stream_pkg.sv */
// constants and types shared by the streaming source port
// assumes a single 20 MHz clock domain with synchronous reset
package stream_pkg;
  localparam int data_width_default = 32;
  localparam int symbol_bits_default = 8;
  localparam int channel_width_default = 4;
  localparam int error_width_default = 2;
  localparam int empty_width_default = 2;
  localparam int ready_delay_default = 1;
  localparam int highest_channel_default = 15;
  // error mask bit positions, one per recognised condition
  localparam int err_bit_parity = 0;
  localparam int err_bit_overrun = 1;
  // values after reset
  localparam logic reset_valid = 1'b0;
  localparam logic reset_marker = 1'b0;
  localparam logic reset_payload = 1'b0;
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_body = 2'b01
  } src_state_t;
endpackage

/* File: ready_delay.sv */
// ready delay line: ready_cycle is ready_in from delay cycles back
// assumes sink ready comes from logic on the same clock
`timescale 1ns/1ps
module ready_delay #(
  parameter int delay = 1
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  input wire logic ready_in,
  output logic ready_cycle
);
  import stream_pkg::*;
  // =========================================
  // shift stages
  // zero delay passes ready straight through; the caller registers
  generate
    if (delay == 0) begin : g_none
      assign ready_cycle = ready_in;
    end else begin : g_line
      logic [delay-1:0] pipe;
      always_ff @(posedge mclk) begin
        if (srst) begin
          pipe <= '0;
        end else if (ce) begin
          pipe[0] <= ready_in;
          for (int k = 1; k < delay; k++) begin
            pipe[k] <= pipe[k-1];
          end
        end
      end
      assign ready_cycle = pipe[delay-1];
    end
  endgenerate
endmodule

/* File: stream_source.sv */
// streaming source port: registers user beats onto a one-way stream
// assumes the sink is logic on mclk; ready is not synchronised
//
// How it works
// - channel 1-128 bits, same-cycle channel number
// - channel port declares highest channel number
// - data 1-4096 bits, layout from parameters
// - error mask 1-256 bits, same cycle
// - each error condition owns one bit
// - one signal per role, no duplicates
// - roles mean the same at both ends
// - optional backpressure stops the source
// - data flows source to sink only
// - beat is one cycle of symbols
// - optional packets, variable length, interleaved channels
// - sink samples only valid ready cycles
// - all source outputs come from registers
// - first and last beat markers
// - empty count on last beat only
`timescale 1ns/1ps
module stream_source
  import stream_pkg::*;
#(
  parameter int data_width = stream_pkg::data_width_default,
  parameter int symbol_bits = stream_pkg::symbol_bits_default,
  parameter int channel_width = stream_pkg::channel_width_default,
  parameter int highest_channel_number =
    stream_pkg::highest_channel_default,
  parameter int error_width = stream_pkg::error_width_default,
  parameter int empty_width = stream_pkg::empty_width_default,
  parameter int ready_to_transfer_delay = stream_pkg::ready_delay_default,
  parameter bit use_backpressure = 1'b1,
  parameter bit use_packets = 1'b1
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  // user side
  input wire logic beat_req,
  input wire logic [data_width-1:0] beat_data,
  input wire logic [channel_width-1:0] beat_channel,
  input wire logic parity_fault,
  input wire logic overrun_fault,
  input wire logic beat_first,
  input wire logic beat_last,
  input wire logic [empty_width-1:0] beat_empty,
  output logic beat_taken,
  output logic packet_open,
  // stream side
  input wire logic ready,
  output logic valid,
  output logic [data_width-1:0] data,
  output logic [channel_width-1:0] channel,
  output logic [error_width-1:0] error,
  output logic startofpacket,
  output logic endofpacket,
  output logic [empty_width-1:0] empty
);
  // =========================================
  // structural checks on widths
  // channel width limits
  // empty width limits
  // registered valid needs at least one cycle of notice
  initial begin
    if (ready_to_transfer_delay < 1 ||
        channel_width < 1 || channel_width > 128 ||
        highest_channel_number >= (2 ** channel_width) ||
        data_width < 1 || data_width > 4096 ||
        error_width < 1 || error_width > 256 ||
        empty_width < 1 || empty_width > 8 ||
        data_width % symbol_bits != 0) begin
      $error("stream_source: illegal port parameters");
    end
  end

  // =========================================
  // ready cycle detection
  logic ready_cycle;
  logic ready_gated;
  assign ready_gated = use_backpressure ? ready : 1'b1;
  // one cycle of the delay is spent in the valid register itself
  ready_delay #(.delay(ready_to_transfer_delay - 1)) u_delay (
    .mclk(mclk),
    .srst(srst),
    .ce(ce),
    .ready_in(ready_gated),
    .ready_cycle(ready_cycle)
  );

  // =========================================
  // beat acceptance decode
  logic send;
  logic [error_width-1:0] next_error;
  logic [channel_width-1:0] safe_channel;
  // only launch into a ready cycle
  // valid is registered, so the request is judged one cycle ahead,
  // against ready seen one cycle less than the full delay back
  assign send = beat_req && ready_cycle;
  always_comb begin
    next_error = '0;
    next_error[err_bit_parity] = parity_fault;
    next_error[err_bit_overrun] = overrun_fault;
  end
  assign safe_channel = (beat_channel > channel_width'(highest_channel_number))
    ? channel_width'(highest_channel_number) : beat_channel;

  // =========================================
  // packet tracking state
  src_state_t state;
  src_state_t next_state;
  always_comb begin
    next_state = state;
    if (send && use_packets) begin
      unique case (state)
        st_idle: next_state = (beat_first && !beat_last) ? st_body : st_idle;
        st_body: next_state = beat_last ? st_idle : st_body;
        default: next_state = st_idle;
      endcase
    end
  end

  // =========================================
  // registered stream outputs
  // all outputs from flip-flops
  // reset keeps valid and markers low
  always_ff @(posedge mclk) begin
    if (srst) begin
      valid <= reset_valid;
      startofpacket <= reset_marker;
      endofpacket <= reset_marker;
      state <= st_idle;
      beat_taken <= 1'b0;
      packet_open <= 1'b0;
    end else if (ce) begin
      valid <= send;
      startofpacket <= send && use_packets && beat_first;
      endofpacket <= send && use_packets && beat_last;
      state <= next_state;
      beat_taken <= send;
      packet_open <= (next_state == st_body);
    end
  end

  // payload cleared by reset so hold checks never meet unknowns
  // one beat per cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      data <= {data_width{reset_payload}};
      channel <= {channel_width{reset_payload}};
      error <= {error_width{reset_payload}};
      empty <= {empty_width{reset_payload}};
    end else if (ce && send) begin
      data <= beat_data;
      channel <= safe_channel;
      error <= next_error;
      empty <= (use_packets && beat_last) ? beat_empty : '0;
    end
  end

  // =========================================
  // checks
  // one port per role, by construction
  // meaning follows the shared role names
  sequence req_in_ready_s;
    ce && beat_req && ready_cycle;
  endsequence

  valid_follows_a: assert property (@(posedge mclk) disable iff (srst)
    req_in_ready_s |=> valid)
    else $error("beat not launched");
  no_valid_idle_a: assert property (@(posedge mclk) disable iff (srst)
    ce && !ready_cycle |=> !valid)
    else $error("valid outside ready cycle");
  valid_ready_a: assert property (@(posedge mclk) disable iff (srst)
    use_backpressure && valid |->
    $past(ready, ready_to_transfer_delay))
    else $error("beat in a non-ready cycle");
  reset_quiet_a: assert property (@(posedge mclk)
    srst |=> !valid && !startofpacket && !endofpacket)
    else $error("activity during reset");
  sop_valid_a: assert property (@(posedge mclk) disable iff (srst)
    startofpacket |-> valid)
    else $error("start marker without valid");
  eop_valid_a: assert property (@(posedge mclk) disable iff (srst)
    endofpacket |-> valid)
    else $error("end marker without valid");
  empty_zero_a: assert property (@(posedge mclk) disable iff (srst)
    valid && !endofpacket |-> empty == '0)
    else $error("empty set off last beat");
  data_hold_a: assert property (@(posedge mclk) disable iff (srst)
    ce && !send |=> $stable(data) && $stable(channel))
    else $error("payload changed without beat");
  data_match_a: assert property (@(posedge mclk) disable iff (srst)
    req_in_ready_s |=> data == $past(beat_data))
    else $error("data not registered");
  chan_range_a: assert property (@(posedge mclk) disable iff (srst)
    valid |-> channel <= channel_width'(highest_channel_number))
    else $error("channel above highest");
  err_map_a: assert property (@(posedge mclk) disable iff (srst)
    req_in_ready_s |=> error[err_bit_overrun] == $past(overrun_fault))
    else $error("error bit mismatch");
  err_parity_a: assert property (@(posedge mclk) disable iff (srst)
    req_in_ready_s |=> error[err_bit_parity] == $past(parity_fault))
    else $error("parity bit mismatch");
  taken_a: assert property (@(posedge mclk) disable iff (srst)
    beat_taken == valid)
    else $error("taken and valid differ");
  bp_off_a: assert property (@(posedge mclk) disable iff (srst)
    !use_backpressure && ce ##1 ce [*2] |-> ready_cycle)
    else $error("ready cycle lost without backpressure");
  pkt_a: assert property (@(posedge mclk) disable iff (srst)
    !use_packets |-> !startofpacket && !endofpacket)
    else $error("markers with packets off");
endmodule

/* File: stream_sink_model.sv */
// sink model: drives ready, counts accepted beats and keeps the data of the last one
// assumes the source sits on mclk with a one-cycle ready delay
`timescale 1ns/1ps
module stream_sink_model (
  input wire logic mclk,
  input wire logic srst,
  input wire logic stall,
  input wire logic valid,
  input wire logic [31:0] data,
  output logic ready,
  output logic [31:0] last_data,
  output int beats
);
  logic ready_seen;
  // ====================================
  // backpressure
  // ready marks later cycle
  always_ff @(posedge mclk) begin
    ready <= !srst && !stall;
    ready_seen <= ready;
  end
  // ====================================
  // capture
  // sample only ready valid cycles
  always_ff @(posedge mclk) begin
    if (srst) begin
      beats <= 0;
    end else if (valid && ready_seen) begin
      beats <= beats + 1;
      last_data <= data;
    end
  end
endmodule

/* File: tb_stream_source.sv */
// self-checking bench for the streaming source port
// assumes package defaults: 32-bit data, 4-bit channel, delay 1
`timescale 1ns/1ps
module tb_stream_source;
  import stream_pkg::*;
  logic mclk = 1'h0;
  logic srst = 1'h1;
  logic stall = 1'h0;
  logic beat_req = 1'h0;
  logic [31:0] beat_data = 32'h0;
  logic [3:0] beat_channel = 4'h0;
  logic [5:0] flags = 6'h0;
  logic beat_taken, packet_open, ready, valid, startofpacket, endofpacket;
  logic [31:0] data, last_data;
  logic [3:0] channel;
  logic [1:0] error, empty;
  logic bare_valid, bare_sop, bare_eop;
  int beats, n, n_errors = 0, cmp_count = 0;
  // ====================================
  // design and far side
  stream_source dut_u (.mclk(mclk), .srst(srst), .ce(1'h1),
    .beat_req(beat_req), .beat_data(beat_data),
    .beat_channel(beat_channel), .parity_fault(flags[3]),
    .overrun_fault(flags[2]), .beat_first(flags[5]),
    .beat_last(flags[4]), .beat_empty(flags[1:0]),
    .beat_taken(beat_taken), .packet_open(packet_open), .ready(ready),
    .valid(valid), .data(data), .channel(channel), .error(error),
    .startofpacket(startofpacket), .endofpacket(endofpacket),
    .empty(empty));
  stream_sink_model sink_u (.mclk(mclk), .srst(srst), .stall(stall),
    .valid(valid), .data(data), .ready(ready), .last_data(last_data),
    .beats(beats));
  // second port with backpressure and packets switched off
  stream_source #(.use_backpressure(1'b0), .use_packets(1'b0)) dut_bare_u (
    .mclk(mclk), .srst(srst), .ce(1'h1), .beat_req(beat_req),
    .beat_data(beat_data), .beat_channel(beat_channel),
    .parity_fault(flags[3]), .overrun_fault(flags[2]),
    .beat_first(flags[5]), .beat_last(flags[4]), .beat_empty(flags[1:0]),
    .beat_taken(), .packet_open(), .ready(ready), .valid(bare_valid),
    .data(), .channel(), .error(), .startofpacket(bare_sop),
    .endofpacket(bare_eop), .empty());
  initial begin
    forever #25 mclk = ~mclk;
  end
  // ====================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // flags: first, last, parity, overrun, empty[1:0]
  task automatic drive(input logic r, input logic [31:0] d,
      input logic [3:0] c, input logic [5:0] f);
    @(posedge mclk);
    beat_req <= r;
    beat_data <= d;
    beat_channel <= c;
    flags <= f;
  endtask
  // looks at the beat launched by the edge just passed
  task automatic look(input logic [31:0] d, input logic [3:0] c,
      input logic sp, input logic ep, input logic [1:0] er, em);
    #1;
    chk(valid, 1'h1);
    chk(beat_taken, 1'h1);
    chk(data, d);
    chk(channel, c);
    chk(error, er);
    chk(startofpacket, sp);
    chk(endofpacket, ep);
    chk(empty, em);
  endtask
  // ====================================
  // scenarios
  task automatic t_reset();
    repeat (16) @(posedge mclk);
    #1;
    chk({valid, startofpacket, endofpacket, beat_taken}, 4'h0);
    chk(packet_open, 1'h0);
    @(posedge mclk);
    srst <= 1'h0;
    repeat (3) @(posedge mclk);
    $display("test reset done");
  endtask
  task automatic t_single();
    drive(1'h1, 32'ha5a5_0001, 4'h5, 6'h3a);
    drive(1'h0, 32'h0, 4'h0, 6'h0);
    look(32'ha5a5_0001, 4'h5, 1'h1, 1'h1, 2'h1, 2'h2);
    @(posedge mclk);
    #1;
    chk(valid, 1'h0);
    chk(last_data, 32'ha5a5_0001);
    $display("test single done");
  endtask
  task automatic t_packet();
    drive(1'h1, 32'h1111_0000, 4'h3, 6'h23);
    drive(1'h1, 32'h2222_0000, 4'h3, 6'h04);
    look(32'h1111_0000, 4'h3, 1'h1, 1'h0, 2'h0, 2'h0);
    chk(packet_open, 1'h1);
    chk({bare_valid, bare_sop, bare_eop}, 3'h4);
    drive(1'h1, 32'h3333_0000, 4'h3, 6'h11);
    look(32'h2222_0000, 4'h3, 1'h0, 1'h0, 2'h2, 2'h0);
    drive(1'h0, 32'h0, 4'h0, 6'h0);
    look(32'h3333_0000, 4'h3, 1'h0, 1'h1, 2'h0, 2'h1);
    $display("test packet done");
  endtask
  task automatic t_refuse();
    int taken, taken_bare;
    taken = 0;
    taken_bare = 0;
    @(posedge mclk);
    beat_req <= 1'h1;
    beat_data <= 32'hdead_0000;
    beat_channel <= 4'h7;
    flags <= 6'h30;
    stall <= 1'h1;
    #1;
    n = beats;
    // request held across the stall: only ready cycles carry beats
    for (int i = 0; i < 7; i++) begin
      @(posedge mclk);
      if (i == 3) begin
        stall <= 1'h0;
      end
      if (i == 5) begin
        beat_req <= 1'h0;
      end
      #1;
      taken += valid;
      taken_bare += bare_valid;
      if (i == 2) begin
        chk({valid, beat_taken}, 2'h0);
      end
    end
    chk(taken, 32'h2);
    chk(beats - n, 32'h2);
    chk(taken_bare, 32'h6);
    drive(1'h1, 32'hbeef_0000, 4'hf, 6'h30);
    drive(1'h0, 32'h0, 4'h0, 6'h0);
    look(32'hbeef_0000, 4'hf, 1'h1, 1'h1, 2'h0, 2'h0);
    $display("test refuse done");
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    t_reset();
    t_single();
    t_packet();
    t_refuse();
    end_of_test();
  end
  // hang guard, far beyond the few dozen cycles the tests need
  initial begin
    repeat (2000) @(posedge mclk);
    n_errors++;
    end_of_test();
  end
endmodule
